// file: src/adc_serial_command_decoder.sv
// Byte command decoder of a delta-sigma converter's serial port.
// Assumes the converter delivers results and calibration outcomes on
// the core clock, and the host drives the serial clock and data in.
`timescale 1ns/1ps
module adc_serial_command_decoder import adc_cmd_pkg::*; (
   // Core clock, reset and enable
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Serial link from the host
   input wire logic link_clk_i,
   input wire logic din_i,
   output logic dout_o,
   // Converter results and calibration
   input wire conv_in_s conv_i,
   input wire cal_result_s cal_i,
   output cal_req_s cal_req_o,
   output logic realign_o,
   output logic sleep_o,
   // Data ready pin and register contents
   output logic result_available_n_o,
   output logic [15:0][7:0] regs_o
);

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      fsm_e st;
      logic [15:0][7:0] regs;
      logic result_available_n_n;
      logic cont;
      logic sleep;
      logic is_write;
      logic [3:0] addr;
      logic [3:0] cnt;
      logic [1:0] idx;
      logic [7:0] tx_byte;
      logic rx_seen;
      logic ack_seen;
      cal_req_s cal_req;
      logic realign;
   } core_s;

   core_s q, d;
   rx_xfer_s rx_link;
   logic ack_tog;
   logic [1:0] sync_q;
   logic rx_ev;
   logic ack_ev;
   logic conv_take;
   logic [7:0] rx_byte;

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Register byte as the host sees it on a read
   function automatic logic [7:0] reg_view(
      input logic [15:0][7:0] r,
      input logic [3:0] a,
      input logic rdy_n
   );
      logic [7:0] v;
      v = r[a];
      if (a == ADDR_ACR) begin
         v[ACR_READY_BIT] = rdy_n;
      end
      return v;
   endfunction : reg_view

   // One of the three result bytes in link order
   function automatic logic [7:0] result_byte(
      input logic [15:0][7:0] r,
      input logic [1:0] i
   );
      logic [7:0] b;
      logic [7:0] v;
      b = '0;
      v = '0;
      // least significant first when the order bit is set, else most significant first
      // The link sends MSB first, so in that order each byte is mirrored here
      if (r[ADDR_ACR][ACR_ORDER_BIT]) begin
         b = r[ADDR_RESULT_LO - {2'h0, i}];
         for (int k = 0; k < 8; k++) begin
            v[k] = b[7 - k];
         end
      end else begin
         v = r[ADDR_RESULT_HI + {2'h0, i}];
      end
      return v;
   endfunction : result_byte

   function automatic core_s soft_reset(input core_s s);
      core_s t;
      t = s;
      t.regs = REG_RESET;
      t.cont = 1'b0;
      t.sleep = 1'b0;
      t.result_available_n_n = 1'b1;
      t.st = ST_IDLE;
      t.tx_byte = '0;
      return t;
   endfunction : soft_reset

   ////////////////////////////////////////////////////////////////////
   // Link domain and crossings

   serial_link u_link (
      .link_clk_i(link_clk_i),
      .reset_i(reset_i),
      .din_i(din_i),
      .dout_o(dout_o),
      .tx_byte_i(q.tx_byte),
      .rx_o(rx_link),
      .ack_tog_o(ack_tog)
   );

   // Toggles cross on two flops; the byte beside them is then stable
   level_sync #(.W(2)) u_sync (
      .clk_i(core_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .d_i({ack_tog, rx_link.tog}),
      .q_o(sync_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;
      d.cal_req.start = 1'b0;
      d.realign = 1'b0;
      rx_ev = (sync_q[0] != q.rx_seen);
      ack_ev = (sync_q[1] != q.ack_seen);
      d.rx_seen = sync_q[0];
      d.ack_seen = sync_q[1];
      rx_byte = rx_link.data;

      // no conversions in sleep
      // Results are also held off while one is being shifted out,
      // so a result read sends bytes of two conversions only if one lands in the cycle its command is decoded
      conv_take = conv_i.valid && !q.sleep && (q.st != ST_CAL)
         && (q.st != ST_RESULT);
      if (conv_take) begin
         d.regs[ADDR_RESULT_LO] = conv_i.value[7:0];
         d.regs[ADDR_RESULT_LO - 4'h1] = conv_i.value[15:8];
         d.regs[ADDR_RESULT_HI] = conv_i.value[23:16];
         d.result_available_n_n = 1'b0;
      end

      case (q.st)
         ST_IDLE: begin
            if (rx_ev && q.cont) begin
               if (rx_byte == OP_END_CONT) begin
                  d.cont = 1'b0;
               end else if (rx_byte == OP_SOFT_RESET) begin
                  d = soft_reset(d);
               end
            end else if (rx_ev) begin
               if (rx_byte == OP_READ_RESULT) begin
                  d.st = ST_RESULT;
                  d.tx_byte = result_byte(q.regs, 2'h0);
                  d.idx = 2'h1;
               end else if (rx_byte == OP_CONT) begin
                  d.cont = 1'b1;
               end else if (rx_byte == OP_END_CONT) begin
                  d.cont = 1'b0;
               end else if (rx_byte[7:4] == NIB_REG_READ) begin
                  d.addr = rx_byte[3:0];
                  d.is_write = 1'b0;
                  d.st = ST_COUNT;
               end else if (rx_byte[7:4] == NIB_REG_WRITE) begin
                  d.addr = rx_byte[3:0];
                  d.is_write = 1'b1;
                  d.st = ST_COUNT;
               end else if (rx_byte >= OP_CAL_FIRST && rx_byte <= OP_CAL_LAST) begin
                  d.cal_req.start = 1'b1;
                  d.cal_req.kind = rx_byte[2:0];
                  d.result_available_n_n = 1'b1;
                  d.st = ST_CAL;
               end else if (rx_byte == OP_RESUME) begin
                  d.sleep = 1'b0;
               end else if (rx_byte == OP_SLEEP) begin
                  d.sleep = 1'b1;
               end else if (rx_byte == OP_REALIGN) begin
                  // restart conversion timing
                  // The pending result is dropped with the old timing
                  d.realign = 1'b1;
                  d.result_available_n_n = 1'b1;
               end else if (rx_byte == OP_SOFT_RESET) begin
                  d = soft_reset(d);
               end
            end else if (conv_take && q.cont) begin
               d.st = ST_RESULT;
               d.tx_byte = result_byte(d.regs, 2'h0);
               d.idx = 2'h1;
            end
         end

         ST_COUNT: begin
            if (rx_ev) begin
               d.cnt = rx_byte[3:0];
               if (q.is_write) begin
                  d.st = ST_WRITE;
               end else begin
                  d.st = ST_READ;
                  d.tx_byte = reg_view(q.regs, q.addr, q.result_available_n_n);
               end
            end
         end

         ST_WRITE: begin
            if (rx_ev) begin
               // consecutive register writes
               // Result registers are read only; the ready bit too
               if (q.addr < ADDR_RESULT_HI) begin
                  d.regs[q.addr] = rx_byte;
                  if (q.addr == ADDR_ACR) begin
                     d.regs[q.addr][ACR_READY_BIT] = 1'b0;
                  end
               end
               d.addr = q.addr + 4'h1;
               if (q.cnt == 4'h0) begin
                  d.st = ST_IDLE;
               end else begin
                  d.cnt = q.cnt - 4'h1;
               end
            end
         end

         ST_READ: begin
            if (ack_ev) begin
               if (q.cnt == 4'h0) begin
                  d.st = ST_IDLE;
                  d.tx_byte = '0;
               end else begin
                  d.cnt = q.cnt - 4'h1;
                  d.addr = q.addr + 4'h1;
                  d.tx_byte = reg_view(q.regs, q.addr + 4'h1, q.result_available_n_n);
               end
            end
         end

         ST_RESULT: begin
            if (rx_ev && q.cont
               && (rx_byte == OP_END_CONT || rx_byte == OP_SOFT_RESET)) begin
               d.cont = 1'b0;
               d.st = ST_IDLE;
               d.tx_byte = '0;
               if (rx_byte == OP_SOFT_RESET) begin
                  d = soft_reset(d);
               end
            end else if (ack_ev) begin
               if (q.idx == RESULT_BYTES) begin
                  d.st = ST_IDLE;
                  d.tx_byte = '0;
                  d.result_available_n_n = 1'b1;
               end else begin
                  d.tx_byte = result_byte(q.regs, q.idx);
                  d.idx = q.idx + 2'h1;
               end
            end
         end

         ST_CAL: begin
            d.result_available_n_n = 1'b1;
            if (cal_i.done) begin
               if (q.cal_req.kind == KIND_FULL || q.cal_req.kind == KIND_OFFSET
                  || q.cal_req.kind == KIND_EXT_OFFSET) begin
                  d.regs[ADDR_OFFSET_LO] = cal_i.offset[7:0];
                  d.regs[ADDR_OFFSET_LO + 4'h1] = cal_i.offset[15:8];
                  d.regs[ADDR_OFFSET_LO + 4'h2] = cal_i.offset[23:16];
               end
               if (q.cal_req.kind == KIND_FULL || q.cal_req.kind == KIND_GAIN
                  || q.cal_req.kind == KIND_EXT_GAIN) begin
                  d.regs[ADDR_SCALE_LO] = cal_i.gain[7:0];
                  d.regs[ADDR_SCALE_LO + 4'h1] = cal_i.gain[15:8];
                  d.regs[ADDR_SCALE_LO + 4'h2] = cal_i.gain[23:16];
               end
               // Ready falls again with the next conversion result
               d.st = ST_IDLE;
            end
         end

         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   // Reset state mirrors a soft reset, with ready high
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '{st: ST_IDLE, regs: REG_RESET, result_available_n_n: 1'b1, default: '0};
      end else if (ce_i) begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign cal_req_o = q.cal_req;
   assign realign_o = q.realign;
   assign sleep_o = q.sleep;
   assign result_available_n_o = q.result_available_n_n;
   assign regs_o = q.regs;

endmodule : adc_serial_command_decoder

// file: src/adc_cmd_pkg.sv
// Shared constants and carriers of the serial command decoder.
// Assumes one core clock and one host-driven serial clock.
package adc_cmd_pkg;
   // Command opcodes
   localparam logic [7:0] OP_READ_RESULT = 8'h01;
   localparam logic [7:0] OP_CONT = 8'h03;
   localparam logic [7:0] OP_END_CONT = 8'h0F;
   localparam logic [7:0] OP_CAL_FIRST = 8'hF0;
   localparam logic [7:0] OP_CAL_LAST = 8'hF4;
   localparam logic [7:0] OP_RESUME = 8'hFB;
   localparam logic [7:0] OP_REALIGN = 8'hFC;
   localparam logic [7:0] OP_SLEEP = 8'hFD;
   localparam logic [7:0] OP_SOFT_RESET = 8'hFE;
   localparam logic [3:0] NIB_REG_READ = 4'h1;
   localparam logic [3:0] NIB_REG_WRITE = 4'h5;
   // Calibration kinds, equal to the opcode low bits
   localparam logic [2:0] KIND_FULL = 3'h0;
   localparam logic [2:0] KIND_OFFSET = 3'h1;
   localparam logic [2:0] KIND_GAIN = 3'h2;
   localparam logic [2:0] KIND_EXT_OFFSET = 3'h3;
   localparam logic [2:0] KIND_EXT_GAIN = 3'h4;
   // Register addresses
   localparam logic [3:0] ADDR_ACR = 4'h2;
   localparam logic [3:0] ADDR_OFFSET_LO = 4'h7;
   localparam logic [3:0] ADDR_SCALE_LO = 4'hA;
   localparam logic [3:0] ADDR_RESULT_HI = 4'hD;
   localparam logic [3:0] ADDR_RESULT_LO = 4'hF;
   // Field positions in the analog control register
   localparam int ACR_READY_BIT = 7;
   localparam int ACR_ORDER_BIT = 3;
   // Power-up register values, index 15 leftmost
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [15:0][7:0] REG_RESET = {
      8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h59, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, SETUP_RESET};
   // Transfer counts
   localparam logic [1:0] RESULT_BYTES = 2'h3;
   localparam logic [2:0] LINK_LAST_BIT = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE, ST_COUNT, ST_WRITE, ST_READ, ST_RESULT, ST_CAL
   } fsm_e;

   typedef struct packed {
      logic valid;
      logic [23:0] value;
   } conv_in_s;

   typedef struct packed {
      logic done;
      logic [23:0] offset;
      logic [23:0] gain;
   } cal_result_s;

   typedef struct packed {
      logic start;
      logic [2:0] kind;
   } cal_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic tog;
   } rx_xfer_s;
endpackage : adc_cmd_pkg

// file: src/level_sync.sv
// Two-flop synchroniser for a small group of toggles.
// Assumes each bit changes at most once per several core cycles.
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 2
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;
   sync_s q, d;

   // First stage feeds only the second
   always_comb begin
      d = q;
      d.meta = d_i;
      d.stable = q.meta;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign q_o = q.stable;
endmodule : level_sync

// file: src/serial_link.sv
// Link side of the serial port, clocked by the host's serial clock.
// Assumes mode with output on rising edges and host sampling on falling.
`timescale 1ns/1ps
module serial_link import adc_cmd_pkg::*; (
   // Link clock and reset
   input wire logic link_clk_i,
   input wire logic reset_i,
   // Serial pins
   input wire logic din_i,
   output logic dout_o,
   // Towards the core
   input wire logic [7:0] tx_byte_i,
   output rx_xfer_s rx_o,
   output logic ack_tog_o
);
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [7:0] shin;
      logic [7:0] shout;
      logic dout;
      logic ack_tog;
      rx_xfer_s rx;
   } link_s;
   link_s q, d;

   always_comb begin
      d = q;
      d.bit_cnt = q.bit_cnt + 3'h1;
      d.shin = {q.shin[6:0], din_i};
      // host wait settles byte
      // The core byte is held steady by then, so it is read directly
      if (q.bit_cnt == 3'h0) begin
         d.dout = tx_byte_i[7];
         d.shout = {tx_byte_i[6:0], 1'b0};
         d.ack_tog = ~q.ack_tog;
      end else begin
         d.dout = q.shout[7];
         d.shout = {q.shout[6:0], 1'b0};
      end
      // Whole byte in: hold it and flip the toggle
      if (q.bit_cnt == LINK_LAST_BIT) begin
         d.rx.data = {q.shin[6:0], din_i};
         d.rx.tog = ~q.rx.tog;
      end
   end

   // Clock runs only during frames; nothing here needs idle edges
   always_ff @(posedge link_clk_i or posedge reset_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout_o = q.dout;
   assign rx_o = q.rx;
   assign ack_tog_o = q.ack_tog;
endmodule : serial_link

// file: testbench/decoder_assertions.sv
// Core-side assertions of the serial command decoder.
// Assumes a bind onto the decoder; only the core clock domain is watched.
`timescale 1ns/1ps
module decoder_assertions import adc_cmd_pkg::*; (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Watched ports
   input wire conv_in_s conv_i,
   input wire cal_result_s cal_i,
   input wire cal_req_s cal_req_o,
   input wire logic realign_o,
   input wire logic sleep_o,
   input wire logic result_available_n_o,
   input wire logic [15:0][7:0] regs_o
);
   logic cal_busy_q;
   logic off_k;
   logic gain_k;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////
   // Calibration in flight from start to done
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cal_busy_q <= 1'b0;
      end else if (cal_req_o.start) begin
         cal_busy_q <= 1'b1;
      end else if (ce_i && cal_i.done) begin
         cal_busy_q <= 1'b0;
      end
   end
   // Which coefficients the held kind refreshes
   assign off_k = cal_req_o.kind inside {KIND_FULL, KIND_OFFSET, KIND_EXT_OFFSET};
   assign gain_k = cal_req_o.kind inside {KIND_FULL, KIND_GAIN, KIND_EXT_GAIN};
   ////////////////////////////////////////////////////////////////
   property p_cal_pulse;
      cal_req_o.start |=> !cal_req_o.start && $stable(cal_req_o.kind);
   endproperty
   a_cal_pulse: assert property (p_cal_pulse) else $error("cal start not a pulse");
   property p_cal_ready;
      cal_req_o.start |=> result_available_n_o [*2];
   endproperty
   a_cal_ready: assert property (p_cal_ready) else $error("ready low at cal start");
   property p_cal_hold;
      cal_busy_q |-> result_available_n_o;
   endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("ready low during cal");
   property p_off_upd;
      cal_busy_q && ce_i && cal_i.done && off_k |=>
         {regs_o[9], regs_o[8], regs_o[7]} == $past(cal_i.offset);
   endproperty
   a_off_upd: assert property (p_off_upd) else $error("offset not stored");
   property p_gain_upd;
      cal_busy_q && ce_i && cal_i.done && gain_k |=>
         {regs_o[12], regs_o[11], regs_o[10]} == $past(cal_i.gain);
   endproperty
   a_gain_upd: assert property (p_gain_upd) else $error("gain not stored");
   property p_gain_keep;
      cal_busy_q && ce_i && cal_i.done && !gain_k |=> $stable(regs_o[12:10]);
   endproperty
   a_gain_keep: assert property (p_gain_keep) else $error("gain changed");
   property p_conv_take;
      ce_i && conv_i.valid && !sleep_o && !cal_busy_q && !cal_req_o.start
         && result_available_n_o |=>
         !result_available_n_o && {regs_o[13], regs_o[14], regs_o[15]} == $past(conv_i.value);
   endproperty
   a_conv_take: assert property (p_conv_take) else $error("result not taken");
   property p_sleep_keep;
      ce_i && sleep_o && conv_i.valid |=> $stable(regs_o[15:13]);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("result taken asleep");
   property p_realign;
      realign_o |=> !realign_o && result_available_n_o;
   endproperty
   a_realign: assert property (p_realign) else $error("realign pulse wrong");
endmodule : decoder_assertions

// file: testbench/host_model.sv
// Host master of the serial port; bursts the serial clock per byte.
// Assumes the decoder samples and shifts on rising edges.
`timescale 1ns/1ps
module host_model (
   // Serial pins
   output logic link_clk_o,
   output logic din_o,
   input wire logic dout_i
);
   // Clock stands low between bytes
   initial begin
      link_clk_o = 1'b0;
      din_o = 1'b0;
   end
   // One byte each way, MSB first; sampled on falling edges
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         din_o = tx[i];
         #80 link_clk_o = 1'b1;
         #80 link_clk_o = 1'b0;
         rx[i] = dout_i;
      end
      // Idle data shows the inverse; the gap covers the reply wait
      din_o = ~tx[0];
      #200;
   endtask : xfer
endmodule : host_model

// file: testbench/testbench.sv
// Self-checking bench of the serial command decoder.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module testbench import adc_cmd_pkg::*; ;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ce_i = 1'b1;
   logic link_clk, din, dout, realign_o, sleep_o, rdy_n;
   conv_in_s conv_i = '0;
   cal_result_s cal_i = '0;
   cal_req_s cal_req_o;
   logic [15:0][7:0] regs_o;
   logic [7:0] exp_r [16];
   logic [7:0] rx;
   int n_fail = 0;
   int checked = 0;
   int n_real = 0;
   int n_cal = 0;
   ////////////////////////////////////////////////////////////////
   // Core clock, 5 ns
   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   adc_serial_command_decoder u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .ce_i(ce_i), .link_clk_i(link_clk), .din_i(din), .dout_o(dout), .conv_i(conv_i),
      .cal_i(cal_i), .cal_req_o(cal_req_o), .realign_o(realign_o), .sleep_o(sleep_o),
      .result_available_n_o(rdy_n), .regs_o(regs_o));
   host_model u_host (.link_clk_o(link_clk), .din_o(din), .dout_i(dout));
   // Pulse counters, since pulses pass before the host task returns
   always @(posedge core_clk_i) begin
      if (realign_o === 1'b1) n_real++;
      if (cal_req_o.start === 1'b1) n_cal++;
   end
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   function automatic logic [23:0] rev24(input logic [23:0] v);
      for (int i = 0; i < 24; i++) rev24[i] = v[23 - i];
   endfunction : rev24
   // Register 2 top bit is never stored; result registers refuse writes
   function automatic void put(input logic [3:0] a, input logic [7:0] d);
      if (a < ADDR_RESULT_HI) exp_r[a] = (a == ADDR_ACR) ? (d & 8'h7F) : d;
   endfunction : put
   task automatic send(input logic [7:0] b);
      // Link edges sit between core edges, so the two clocks stay apart in phase
      @(negedge core_clk_i);
      #1.3;
      u_host.xfer(b, rx);
   endtask : send
   task automatic cmp_regs();
      for (int i = 0; i < 16; i++) check(regs_o[i], exp_r[i]);
   endtask : cmp_regs
   task automatic wr2(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1);
      send({NIB_REG_WRITE, a});
      send({4'($urandom), 4'h1});
      send(d0);
      send(d1);
      put(a, d0);
      put(a + 4'h1, d1);
   endtask : wr2
   task automatic rd(input logic [3:0] a, input logic [3:0] n);
      logic [3:0] k;
      k = a;
      send({NIB_REG_READ, a});
      send({4'($urandom), n});
      for (int i = 0; i <= n; i++) begin
         send(8'h00);
         check(rx, (k == ADDR_ACR) ? {rdy_n, exp_r[k][6:0]} : exp_r[k]);
         k++;
      end
   endtask : rd
   task automatic get3(output logic [23:0] r);
      for (int i = 0; i < 3; i++) begin
         send(8'h00);
         r = {r[15:0], rx};
      end
   endtask : get3
   // New result pulse; take says whether it should land
   task automatic conv(input logic [23:0] v, input logic take);
      @(negedge core_clk_i) conv_i = {1'b1, v};
      @(negedge core_clk_i) conv_i.valid = 1'b0;
      if (take) {exp_r[13], exp_r[14], exp_r[15]} = v;
   endtask : conv
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [23:0] v, r, off, gn;
      void'($urandom(32'h8a3a));
      repeat (2) @(negedge core_clk_i);
      reset_i = 1'b0;
      for (int i = 0; i < 16; i++) exp_r[i] = REG_RESET[i];
      cmp_regs();
      wr2(4'h4, 8'($urandom), 8'($urandom));
      wr2(4'hF, 8'($urandom), 8'($urandom));
      cmp_regs();
      rd(4'hF, 4'h2);
      rd(4'h4, 4'h1);
      // Sixteen registers, wrapping, with the ready bit shown high
      rd(4'h9, 4'hF);
      // Single read, then reversed bit order
      for (int b = 0; b < 2; b++) begin
         wr2(ADDR_ACR, b ? 8'h08 : 8'h00, exp_r[3]);
         v = 24'($urandom);
         conv(v, 1'b1);
         check(rdy_n, 1'b0);
         send(OP_READ_RESULT);
         get3(r);
         check(r, b ? rev24(v) : v);
         check(rdy_n, 1'b1);
      end
      wr2(ADDR_ACR, 8'h00, exp_r[3]);
      // Continuous mode: two results, then stop after ready falls
      send(OP_CONT);
      for (int i = 0; i < 3; i++) begin
         v = 24'($urandom);
         conv(v, 1'b1);
         repeat (12) @(negedge core_clk_i);
         if (i == 2) break;
         get3(r);
         check(r, v);
      end
      // stop sent while ready is low
      send(OP_END_CONT);
      rd(ADDR_RESULT_HI, 4'h2);
      // Every calibration kind
      for (int k = 0; k <= 4; k++) begin
         send(OP_CAL_FIRST + 8'(k));
         check(24'(n_cal), 24'(k + 1));
         check(cal_req_o.kind, 24'(k));
         check(rdy_n, 1'b1);
         off = 24'($urandom);
         gn = 24'($urandom);
         @(negedge core_clk_i) cal_i = {1'b1, off, gn};
         @(negedge core_clk_i) cal_i.done = 1'b0;
         if (k inside {0, 1, 3}) {exp_r[9], exp_r[8], exp_r[7]} = off;
         if (k inside {0, 2, 4}) {exp_r[12], exp_r[11], exp_r[10]} = gn;
         cmp_regs();
         conv(24'($urandom), 1'b1);
         check(rdy_n, 1'b0);
      end
      // Enable low freezes the core: a result pulse must not land
      @(negedge core_clk_i) ce_i = 1'b0;
      conv(24'($urandom), 1'b0);
      @(negedge core_clk_i) ce_i = 1'b1;
      check(rdy_n, 1'b0);
      cmp_regs();
      // Sleep ignores results and unknown bytes; resume wakes
      send(OP_SLEEP);
      check(sleep_o, 1'b1);
      conv(24'($urandom), 1'b0);
      // host leaves sleep only by resume or soft reset
      send(8'h77);
      check(sleep_o, 1'b1);
      cmp_regs();
      send(OP_RESUME);
      check(sleep_o, 1'b0);
      send(OP_REALIGN);
      check(24'(n_real), 24'h1);
      check(rdy_n, 1'b1);
      // Soft reset ends continuous mode and restores registers
      wr2(4'h4, 8'($urandom), 8'($urandom));
      send(OP_CONT);
      send(OP_SOFT_RESET);
      for (int i = 0; i < 16; i++) exp_r[i] = REG_RESET[i];
      cmp_regs();
      rd(4'h4, 4'h1);
      tally_and_finish();
   end
endmodule : testbench
bind adc_serial_command_decoder decoder_assertions u_chk (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .ce_i(ce_i), .conv_i(conv_i), .cal_i(cal_i), .cal_req_o(cal_req_o),
   .realign_o(realign_o), .sleep_o(sleep_o), .result_available_n_o(result_available_n_o),
   .regs_o(regs_o));
